// ### fifo_pkg.sv
// constants for the 9-bit two-port fifo block
// assumes all pins are sampled on the system clock ref_clk
package fifo_pkg;
  localparam int          DATA_W      = 9;
  localparam int          OFS_W       = 8;
  localparam int          CMP_W       = 16;
  localparam int          ADDR_W_DEF  = 6;
  localparam logic [7:0]  OFS_RESET   = 8'h07;
  // offset register sequence positions
  localparam logic [1:0]  OFS_EMPTY_LO = 2'h0;
  localparam logic [1:0]  OFS_EMPTY_HI = 2'h1;
  localparam logic [1:0]  OFS_FULL_LO  = 2'h2;
  localparam logic [1:0]  OFS_FULL_HI  = 2'h3;
  // positions in the synchronised pin vector
  localparam int          PIN_W       = 17;
  localparam int          P_DATA      = 0;
  localparam int          P_WRITE_ENABLE_PRIMARY_N      = 9;
  localparam int          P_WRITE_ENABLE_SECOND      = 10;
  localparam int          P_WCLK      = 11;
  localparam int          P_RCLK      = 12;
  localparam int          P_RENA      = 13;
  localparam int          P_RENB      = 14;
  localparam int          P_OE        = 15;
  localparam int          P_CLR       = 16;
endpackage : fifo_pkg

// ### dual_clock_sync_fifo_x9.sv
// 9-bit first-in first-out buffer with write and read ports on pin clocks
// assumes both port clocks are far slower than ref_clk and get sampled by it
//
// Function
// R1 - nine-bit data in, out and storage
// R2 - dual-port array, depth set by parameter
// R3 - mode pin sampled while clear held low
// R4 - two-enable mode: write when enables active
// R5 - offset mode: primary enable alone writes buffer
// R6 - load low writes offset register instead
// R7 - load low read shows offset register
// R8 - read edge with enables low outputs word
// R9 - full blocks every buffer write
// R10 - empty blocks every buffer read
// R11 - empty keeps last valid word on output
// R12 - empty flag low, read side only
// R13 - full flag low, write side only
// R14 - almost-empty low at or below offset
// R15 - almost-full low at full threshold
// R16 - clear empties buffer, data goes low
// R17 - all flags valid after clear
// R18 - controller clears before first access
// R19 - no access while clear held low
// R20 - output enable low drives data outputs
// R21 - writes sequential, independent of reads
// R22 - four offset bytes cycle, position retained
// R23 - both offsets default to seven
// R24 - almost-empty registered on read edges
// R25 - almost-full registered on write edges
// R26 - pointers cross port domains safely
// R27 - no simultaneous offset write and read
`timescale 1ns/100ps
module dual_clock_sync_fifo_x9
  import fifo_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  // system
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // write port pins
  input  wire logic [DATA_W-1:0] write_data,
  input  wire logic              write_enable_primary_n,
  input  wire logic              write_enable_second_or_offset_load,
  input  wire logic              write_clk,
  // read port pins
  input  wire logic              read_enable_a_n,
  input  wire logic              read_enable_b_n,
  input  wire logic              read_clk,
  input  wire logic              output_enable_n,
  output logic      [DATA_W-1:0] read_data,
  output logic                   read_data_oe,
  // status and clear
  input  wire logic              fifo_clear_n,
  output logic                   empty_flag_n,
  output logic                   full_flag_n,
  output logic                   almost_empty_flag_n,
  output logic                   almost_full_flag_n
);

  // ********************************
  // sizes and helpers
  // ********************************
  localparam int               CNT_W   = ADDR_W + 1;
  localparam int               DEPTH   = 1 << ADDR_W;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] ONE_C   = CNT_W'(1);

  // stretch a word count to the offset width
  function automatic logic [CMP_W-1:0] widen(
    input logic [CNT_W-1:0] v
  );
    widen = CMP_W'(v);
  endfunction : widen

  // next position in the four-byte offset sequence
  function automatic logic [1:0] next_pos(
    input logic [1:0] p
  );
    next_pos = p + 2'h1;
  endfunction : next_pos

  // count strictly above a sixteen-bit threshold
  function automatic logic above(
    input logic [CNT_W-1:0] v,
    input logic [CMP_W-1:0] thr
  );
    above = (widen(v) > thr);
  endfunction : above

  // ********************************
  // pin synchronisers
  // ********************************
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;

  // two stages; only the second one is read by logic
  always_ff @(posedge ref_clk) begin
    pin_s1_r <= {fifo_clear_n, output_enable_n, read_enable_b_n,
                 read_enable_a_n, read_clk, write_clk,
                 write_enable_second_or_offset_load,
                 write_enable_primary_n, write_data};
  end

  always_ff @(posedge ref_clk) begin
    pin_s2_r <= pin_s1_r;
  end

  // ********************************
  // synchronised pin names
  // ********************************
  logic              clear_n_s;
  logic              oe_n_s;
  logic              ren_b_n_s;
  logic              ren_a_n_s;
  logic              rclk_s;
  logic              wclk_s;
  logic              write_enable_second_s;
  logic              write_enable_primary_n_n_s;
  logic [DATA_W-1:0] din;

  assign clear_n_s = pin_s2_r[P_CLR];
  assign oe_n_s    = pin_s2_r[P_OE];
  assign ren_b_n_s = pin_s2_r[P_RENB];
  assign ren_a_n_s = pin_s2_r[P_RENA];
  assign rclk_s    = pin_s2_r[P_RCLK];
  assign wclk_s    = pin_s2_r[P_WCLK];
  assign write_enable_second_s    = pin_s2_r[P_WRITE_ENABLE_SECOND];
  assign write_enable_primary_n_n_s  = pin_s2_r[P_WRITE_ENABLE_PRIMARY_N];
  assign din       = pin_s2_r[P_DATA +: DATA_W];

  // ********************************
  // port clock edges
  // ********************************
  logic wclk_prev_r;
  logic rclk_prev_r;
  logic w_edge;
  logic r_edge;

  always_ff @(posedge ref_clk) begin
    wclk_prev_r <= wclk_s;
  end

  always_ff @(posedge ref_clk) begin
    rclk_prev_r <= rclk_s;
  end

  // rising edges of the sampled port clocks
  assign w_edge = wclk_s & ~wclk_prev_r;
  assign r_edge = rclk_s & ~rclk_prev_r;

  // ********************************
  // clear
  // ********************************
  logic clr;

  // pin clear acts like the system reset on the buffer
  assign clr = srst | ~clear_n_s;

  // ********************************
  // mode capture
  // ********************************
  logic two_en_r;

  // last level seen while clear is held low decides the mode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      two_en_r <= 1'b1;
    end else if (~clear_n_s) begin
      two_en_r <= write_enable_second_s; // R3
    end
  end

  // ********************************
  // access decode
  // ********************************
  logic w_req;
  logic ofs_wr;
  logic r_req;
  logic ofs_rd;

  // load high doubles as second enable in either mode
  assign w_req  = w_edge & ~write_enable_primary_n_n_s & write_enable_second_s; // R4 R5
  assign ofs_wr = w_edge & ~two_en_r & ~write_enable_primary_n_n_s & ~write_enable_second_s; // R6
  assign r_req  = r_edge & ~ren_a_n_s & ~ren_b_n_s;
  assign ofs_rd = r_req & ~two_en_r & ~write_enable_second_s; // R7

  // ********************************
  // pointers and count
  // ********************************
  logic [CNT_W-1:0] wr_ptr_r;
  logic [CNT_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] cnt_nxt;
  logic             w_do;
  logic             r_do;

  // both ports are sampled on ref_clk, so the pointer difference is
  // always coherent and no gray-coded crossing is needed
  assign cnt = wr_ptr_r - rd_ptr_r; // R26

  // full and empty block whatever the enables say
  assign w_do = w_req & full_flag_n & (cnt != DEPTH_C) & ~clr; // R9
  assign r_do = r_req & ~ofs_rd & empty_flag_n & (cnt != '0) & ~clr; // R10

  // count after this cycle's accesses, seen by both flag sides
  assign cnt_nxt = cnt + CNT_W'(w_do) - CNT_W'(r_do);

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      wr_ptr_r <= '0; // R16
    end else if (w_do) begin
      wr_ptr_r <= wr_ptr_r + ONE_C; // R21
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      rd_ptr_r <= '0; // R16
    end else if (r_do) begin
      rd_ptr_r <= rd_ptr_r + ONE_C;
    end
  end

  // ********************************
  // storage array
  // ********************************
  logic [DATA_W-1:0] mem [DEPTH]; // R1 R2

  // sequential fill, untouched by read activity
  always_ff @(posedge ref_clk) begin
    if (w_do) begin
      mem[wr_ptr_r[ADDR_W-1:0]] <= din; // R21
    end
  end

  // ********************************
  // offset registers
  // ********************************
  logic [OFS_W-1:0] ofs_empty_lo_r;
  logic [OFS_W-1:0] ofs_empty_hi_r;
  logic [OFS_W-1:0] ofs_full_lo_r;
  logic [OFS_W-1:0] ofs_full_hi_r;
  logic [1:0]       ofs_idx_r;
  logic [CMP_W-1:0] empty_ofs;
  logic [CMP_W-1:0] full_ofs;
  logic [OFS_W-1:0] ofs_sel;

  assign empty_ofs = {ofs_empty_hi_r, ofs_empty_lo_r};
  assign full_ofs  = {ofs_full_hi_r, ofs_full_lo_r};

  // one shared position for writes and reads; it steps only once when both land in one cycle
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ofs_idx_r <= OFS_EMPTY_LO;
    end else if (ofs_wr) begin
      ofs_idx_r <= next_pos(ofs_idx_r); // R22
    end else if (ofs_rd) begin
      ofs_idx_r <= next_pos(ofs_idx_r); // R22 R27
    end
  end

  // empty offset low byte
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ofs_empty_lo_r <= OFS_RESET; // R23
    end else if (ofs_wr && ofs_idx_r == OFS_EMPTY_LO) begin
      ofs_empty_lo_r <= din[OFS_W-1:0]; // R6
    end
  end

  // empty offset high byte
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ofs_empty_hi_r <= '0;
    end else if (ofs_wr && ofs_idx_r == OFS_EMPTY_HI) begin
      ofs_empty_hi_r <= din[OFS_W-1:0]; // R6
    end
  end

  // full offset low byte
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ofs_full_lo_r <= OFS_RESET; // R23
    end else if (ofs_wr && ofs_idx_r == OFS_FULL_LO) begin
      ofs_full_lo_r <= din[OFS_W-1:0]; // R6
    end
  end

  // full offset high byte
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      ofs_full_hi_r <= '0;
    end else if (ofs_wr && ofs_idx_r == OFS_FULL_HI) begin
      ofs_full_hi_r <= din[OFS_W-1:0]; // R6
    end
  end

  // byte at the shared position, for offset reads
  always_comb begin
    case (ofs_idx_r)
      OFS_EMPTY_LO: ofs_sel = ofs_empty_lo_r;
      OFS_EMPTY_HI: ofs_sel = ofs_empty_hi_r;
      OFS_FULL_LO:  ofs_sel = ofs_full_lo_r;
      OFS_FULL_HI:  ofs_sel = ofs_full_hi_r;
      default:      ofs_sel = ofs_empty_lo_r;
    endcase
  end

  // ********************************
  // read data
  // ********************************
  // offset byte lands in the low bits with bit 8 clear
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      read_data <= '0; // R16
    end else if (ofs_rd) begin
      read_data <= DATA_W'(ofs_sel); // R7
    end else if (r_do) begin
      read_data <= mem[rd_ptr_r[ADDR_W-1:0]]; // R8 R11
    end
  end

  // ********************************
  // output enable
  // ********************************
  // registered inverse of the pin, high while outputs drive
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      read_data_oe <= 1'b0;
    end else begin
      read_data_oe <= ~oe_n_s; // R20
    end
  end

  // ********************************
  // status flags, read side
  // ********************************
  // both read-side flags refresh only on read clock edges
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      empty_flag_n <= 1'b0; // R16 R17
    end else if (r_edge) begin
      empty_flag_n <= (cnt_nxt != '0); // R12
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      almost_empty_flag_n <= 1'b0; // R17
    end else if (r_edge) begin
      almost_empty_flag_n <= above(cnt_nxt, empty_ofs); // R14 R24
    end
  end

  // ********************************
  // status flags, write side
  // ********************************
  logic [CNT_W-1:0] free_nxt;

  // free locations after this cycle's accesses
  assign free_nxt = DEPTH_C - cnt_nxt;

  // both write-side flags refresh only on write clock edges
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      full_flag_n <= 1'b1; // R17
    end else if (w_edge) begin
      full_flag_n <= (cnt_nxt != DEPTH_C); // R13
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      almost_full_flag_n <= 1'b1; // R17
    end else if (w_edge) begin
      almost_full_flag_n <= above(free_nxt, full_ofs); // R15 R25
    end
  end

endmodule : dual_clock_sync_fifo_x9

// ### port_clocks.sv
// far-side write and read port clocks, free-running
// assumes a 1 ns time unit; both run at 160 ns, read_clk 37 ns behind write_clk
`timescale 1ns/100ps
module port_clocks (
  // port clocks
  output logic write_clk,
  output logic read_clk
);
  initial write_clk = 1'b0;
  always #80 write_clk = ~write_clk;
  initial begin
    read_clk = 1'b0;
    #37 forever #80 read_clk = ~read_clk;
  end
endmodule : port_clocks

// ### dual_clock_sync_fifo_x9_assertions.sv
// checker on the fifo top ports
// assumes port clocks far slower than ref_clk
`timescale 1ns/100ps
module fifo_chk
  import fifo_pkg::*;
(
  // clocks and reset
  input wire logic              ref_clk,
  input wire logic              srst,
  input wire logic              write_clk,
  input wire logic              read_clk,
  // control pins
  input wire logic              write_enable_second_or_offset_load,
  input wire logic              output_enable_n,
  input wire logic              fifo_clear_n,
  // outputs
  input wire logic [DATA_W-1:0] read_data,
  input wire logic              read_data_oe,
  input wire logic              empty_flag_n,
  input wire logic              full_flag_n,
  input wire logic              almost_empty_flag_n,
  input wire logic              almost_full_flag_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic       wclk_r, rclk_r;
  logic [3:0] wcnt_r, rcnt_r;
  always_ff @(posedge ref_clk) begin
    wclk_r <= write_clk;
    rclk_r <= read_clk;
  end
  // cycles since a port clock rise or a clear
  always_ff @(posedge ref_clk) begin
    if ((write_clk && !wclk_r) || !fifo_clear_n) wcnt_r <= 4'h0;
    else if (wcnt_r != 4'hf) wcnt_r <= wcnt_r + 4'h1;
  end
  always_ff @(posedge ref_clk) begin
    if ((read_clk && !rclk_r) || !fifo_clear_n) rcnt_r <= 4'h0;
    else if (rcnt_r != 4'hf) rcnt_r <= rcnt_r + 4'h1;
  end
  sequence quiet_s;
    (!empty_flag_n && fifo_clear_n
      && write_enable_second_or_offset_load) [*4];
  endsequence
  reset_flags_a: assert property (
    $fell(srst) |-> !empty_flag_n && full_flag_n && !almost_empty_flag_n
      && almost_full_flag_n && read_data == 9'h000)
    else $error("flags or data wrong after reset");
  oe_drive_a: assert property (!output_enable_n [*5] |-> read_data_oe)
    else $error("output not driven");
  oe_float_a: assert property (output_enable_n [*5] |-> !read_data_oe)
    else $error("output not released");
  flag_excl_a: assert property (empty_flag_n || full_flag_n)
    else $error("empty and full together");
  ae_empty_a: assert property (!empty_flag_n |-> !almost_empty_flag_n)
    else $error("almost empty high while empty");
  af_full_a: assert property (!full_flag_n |-> !almost_full_flag_n)
    else $error("almost full high while full");
  hold_out_a: assert property (quiet_s |=> $stable(read_data))
    else $error("read data moved while empty");
  full_domain_a: assert property (
    $changed(full_flag_n) |-> wcnt_r < 4'h8)
    else $error("full flag moved without write clock");
  empty_domain_a: assert property (
    $changed(empty_flag_n) |-> rcnt_r < 4'h8)
    else $error("empty flag moved without read clock");
endmodule : fifo_chk

// ### test_dual_clock_sync_fifo_x9.sv
// self-checking bench for the 9-bit fifo on pin-level port clocks
// assumes fifo_pkg, port_clocks and fifo_chk compiled first
`timescale 1ns/100ps
module test_dual_clock_sync_fifo_x9
  import fifo_pkg::*;
;
  logic              ref_clk, srst, write_clk, read_clk, fifo_clear_n;
  logic              write_enable_primary_n, output_enable_n;
  logic              write_enable_second_or_offset_load;
  logic              read_enable_a_n, read_enable_b_n;
  logic [DATA_W-1:0] write_data, read_data;
  logic              read_data_oe, empty_flag_n, full_flag_n;
  logic              almost_empty_flag_n, almost_full_flag_n;
  int                n_fail, num_checks, cyc;
  logic [DATA_W-1:0] ofs [5] = '{9'h002, 9'h000, 9'h003, 9'h000, 9'h001};

  dual_clock_sync_fifo_x9 #(.ADDR_W(6)) u_dual_clock_sync_fifo_x9 (.*);
  port_clocks u_port_clocks (.*);

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize;
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [8:0] got, exp, input string nm);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic per(input int n);
    repeat (n * 16) @(posedge ref_clk);
  endtask : per

  // enables held across a whole port clock high phase
  task automatic wr(input logic [8:0] d, input logic w2);
    @(negedge write_clk);
    @(posedge ref_clk);
    write_data <= d;
    write_enable_primary_n <= 1'b0;
    write_enable_second_or_offset_load <= w2;
    @(negedge write_clk);
    @(posedge ref_clk);
    write_enable_primary_n <= 1'b1;
  endtask : wr

  task automatic rd(input logic [8:0] exp, input string nm);
    @(negedge read_clk);
    @(posedge ref_clk);
    read_enable_a_n <= 1'b0;
    read_enable_b_n <= 1'b0;
    @(negedge read_clk);
    @(posedge ref_clk);
    read_enable_a_n <= 1'b1;
    read_enable_b_n <= 1'b1;
    chk(read_data, exp, nm);
  endtask : rd

  task automatic clear(input logic m);
    @(posedge ref_clk);
    write_enable_second_or_offset_load <= m;
    fifo_clear_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    fifo_clear_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : clear

  function automatic logic [8:0] val(input int i);
    return 9'h1ff - 9'(i * 37);
  endfunction : val

  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    fifo_clear_n = 1'b1;
    write_enable_primary_n = 1'b1;
    write_enable_second_or_offset_load = 1'b1;
    read_enable_a_n = 1'b1;
    read_enable_b_n = 1'b1;
    output_enable_n = 1'b0;
    write_data = 9'h000;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    clear(1'b1);
    chk(empty_flag_n, 1'b0, "empty");
    chk(full_flag_n, 1'b1, "full");
    chk(almost_full_flag_n, 1'b1, "almost full");
    chk(almost_empty_flag_n, 1'b0, "almost empty");
    rd(9'h000, "empty read");
    wr(9'h155, 1'b0);
    per(2);
    chk(empty_flag_n, 1'b0, "second enable low");
    for (int i = 0; i < 8; i++) begin
      wr(val(i), 1'b1);
      per(2);
      chk(almost_empty_flag_n, i == 7, "almost empty");
    end
    for (int i = 0; i < 8; i++) rd(val(i), "order");
    per(2);
    chk(empty_flag_n, 1'b0, "drained");
    rd(val(7), "hold on empty");
    for (int i = 0; i < 65; i++) begin
      wr(9'(i), 1'b1);
      if (i > 54) chk(almost_full_flag_n, i < 56, "almost full");
      if (i > 61) chk(full_flag_n, i < 63, "full");
    end
    rd(9'h000, "no overwrite");
    output_enable_n <= 1'b1;
    per(1);
    chk(read_data_oe, 1'b0, "output enable");
    output_enable_n <= 1'b0;
    per(1);
    chk(read_data_oe, 1'b1, "output enable");
    clear(1'b0);
    for (int i = 0; i < 5; i++) wr(ofs[i], 1'b0);
    rd(9'h000, "offset read");
    rd(9'h003, "offset read");
    wr(9'h0aa, 1'b1);
    wr(9'h055, 1'b1);
    per(2);
    chk(almost_empty_flag_n, 1'b1, "programmed offset");
    summarize();
  end
endmodule : test_dual_clock_sync_fifo_x9

bind dual_clock_sync_fifo_x9 fifo_chk u_fifo_chk (.*);
